/* dv/hrpwm_gate_model.sv */
`timescale 1ns/10ps
module hrpwm_gate_model (
	input  wire logic                    sys_clk,
	input  wire hrpwm_pkg::hrpwm_drive_s drive,
	input  wire logic                    ocp_cmd,
	input  wire logic                    ov_cmd,
	input  wire logic                    uv_cmd,
	input  wire logic [7:0]              phase_cmd,
	output hrpwm_pkg::hrpwm_sense_s      sense
);
	// comparators as the converter shows them; levels only, no glitch filtering here
	always_comb begin
		sense.ocp_raw = ocp_cmd;
		sense.ov_level = ov_cmd;
		sense.uv_level = uv_cmd;
		sense.phase_time = phase_cmd;
	end
endmodule

/* dv/tb.sv */
`timescale 1ns/10ps
`include "hrpwm_params.svh"
module tb;
	logic                    sys_clk = 0;
	logic                    reset_n = 0;
	logic                    hsel = 0;
	logic                    hwrite = 0;
	logic [31:0]             haddr = 0;
	logic [31:0]             hwdata = 0;
	logic [31:0]             hrdata;
	logic [31:0]             d;
	logic [31:0]             seed = 33;
	logic [1:0]              htrans = 0;
	logic [2:0]              hsize = 3'h2;
	logic                    hreadyout;
	logic                    hresp;
	logic                    ocp = 0;
	logic                    ov = 0;
	logic                    uv = 0;
	logic [7:0]              ph = 8'h00;
	hrpwm_pkg::hrpwm_sense_s sense;
	hrpwm_pkg::hrpwm_drive_s drive;
	int                      fails = 0;
	int                      n_compared = 0;
	int                      cyc = 0;
	int                      nirq[3] = '{0, 0, 0};
	int                      p, c, f, dt, x, y, h, oh, ol, n0, inv, en;
	always #50 sys_clk = ~sys_clk;
	hrpwm_stage DUT (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .sense(sense), .drive(drive));
	hrpwm_gate_model gates (.sys_clk(sys_clk), .drive(drive), .ocp_cmd(ocp), .ov_cmd(ov), .uv_cmd(uv),
		.phase_cmd(ph), .sense(sense));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask
	// hold the address phase until hready, then the data phase until hready again
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bus(1'b1, a, v);
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, d);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic meas(input int n);
		h = 0;
		oh = 0;
		ol = 0;
		repeat (n) begin
			@(posedge sys_clk);
			h += int'(drive.hires === 1'b1);
			oh += int'(drive.out_high === 1'b1);
			ol += int'(drive.out_low === 1'b1);
		end
	endtask
	// a short level pulse: one trigger, then time for the adjust to land
	task automatic vp(input logic [2:0] v);
		{ocp, ov, uv} <= v;
		wt(4);
		{ocp, ov, uv} <= 3'b000;
		wt(10);
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (drive.irq_ocp === 1'b1) nirq[0]++;
		if (drive.irq_ovp === 1'b1) nirq[1]++;
		if (drive.irq_uvp === 1'b1) nirq[2]++;
		if (cyc == 30000) begin
			fails++;
			close_out();
		end
	end
	initial begin
		wt(10);
		reset_n <= 1'b1;
		rc("ctrl", `HRPWM_A_CTRL, 0);
		rc("status", `HRPWM_A_STATUS, 0);
		wr(8'h40, 32'hffff_ffff);
		rc("unmapped", 8'h40, 0);
		wr(`HRPWM_A_FINE, 9);
		wr(`HRPWM_A_COARSE, 8'h10);
		wr(`HRPWM_A_FINE, 3);
		rc("hold", `HRPWM_A_FINE, 3);
		rc("coarse", `HRPWM_A_COARSE, 8'h10);
		rc("fine", `HRPWM_A_FINE, 9);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			// period kept above coarse so the duty never saturates
			p = 16 + seed[4:0];
			c = 6 + seed[10:8];
			f = seed[15:12];
			dt = seed[17:16];
			en = i % 2;
			inv = i / 2;
			wr(`HRPWM_A_PERIOD, p);
			wr(`HRPWM_A_DEADTIME, dt);
			wr(`HRPWM_A_FINE, f);
			wr(`HRPWM_A_COARSE, c);
			wr(`HRPWM_A_OUT_CTRL, inv * 3);
			wr(`HRPWM_A_CTRL, en * 2 + 1);
			wt(3 * p + 20);
			meas(p + 1);
			x = c + int'(f != 0);
			y = en ? x - dt : x;
			chk("hires", x, h);
			chk("out_high", inv ? p + 1 - y : y, oh);
			chk("out_low", inv ? x : p + 1 - x, ol);
			chk("tap", f, drive.tap);
		end
		wr(`HRPWM_A_OUT_CTRL, 32'h220);
		wr(`HRPWM_A_CTRL, 32'h10001);
		for (int k = 0; k < 4; k++) begin
			if (k == 3) wr(`HRPWM_A_CTRL, 1);
			n0 = nirq[k % 3];
			{ocp, ov, uv} <= 3'b100 >> (k % 3);
			wt(6);
			chk("forced_high", 1, drive.out_high);
			if (k == 1 || k == 2) chk("forced_low", 0, drive.out_low);
			rc("fault_status", `HRPWM_A_STATUS, 32'h2 << (k % 3));
			{ocp, ov, uv} <= 3'b000;
			wt(6);
			chk("event", (k == 3) ? n0 : n0 + 1, nirq[k % 3]);
			meas(p + 1);
			chk("resume", p + 1 - x, ol);
		end
		wr(`HRPWM_A_CTRL, 32'h10301);
		n0 = nirq[0];
		ocp <= 1'b1;
		wt(4);
		ocp <= 1'b0;
		wt(12);
		chk("deb_short", n0, nirq[0]);
		ocp <= 1'b1;
		wt(14);
		rc("deb_long", `HRPWM_A_STATUS, 32'h2);
		ocp <= 1'b0;
		wt(14);
		chk("deb_event", n0 + 1, nirq[0]);
		wr(`HRPWM_A_PHASE_NOM, 20);
		ph <= 8'd30;
		wt(10);
		chk("relock_off", 0, drive.relock);
		rc("flag_off", `HRPWM_A_STATUS, 0);
		ph <= 8'd29;
		wr(`HRPWM_A_CTRL, 5);
		wt(10);
		chk("below_limit", 0, drive.relock);
		ph <= 8'd30;
		wt(6);
		chk("relock_on", 1, drive.relock);
		rc("flag_on", `HRPWM_A_STATUS, 1);
		ph <= 8'd20;
		wt(300);
		chk("relock_end", 0, drive.relock);
		wr(`HRPWM_A_STATUS, 1);
		rc("flag_clear", `HRPWM_A_STATUS, 0);
		wr(`HRPWM_A_PHASE_NOM, 0);
		wr(`HRPWM_A_PERIOD, 15);
		wr(`HRPWM_A_FINE, 0);
		wr(`HRPWM_A_COARSE, 16);
		wr(`HRPWM_A_DUTY_MAX, 32'h105);
		wr(`HRPWM_A_DUTY_MIN, 32'h0f0);
		wr(`HRPWM_A_ADJ_STEPS, 32'hf3);
		wr(`HRPWM_A_ADJ_DELAY, 1);
		wr(`HRPWM_A_CTRL, 1);
		wt(40);
		wr(`HRPWM_A_CTRL, 9);
		wt(40);
		vp(3'b010);
		rc("adj_max", `HRPWM_A_ADJ_BUF, 32'h105);
		rc("hw_ctl", `HRPWM_A_STATUS, 32'h30);
		wt(80);
		vp(3'b001);
		rc("adj_uv", `HRPWM_A_ADJ_BUF, 32'h102);
		vp(3'b010);
		rc("adj_wait", `HRPWM_A_ADJ_BUF, 32'h102);
		wt(80);
		// hw control bit written as one so the buffer stays the base
		wr(`HRPWM_A_CTRL, 32'h39);
		vp(3'b010);
		rc("adj_dir", `HRPWM_A_ADJ_BUF, 32'h0f3);
		wt(80);
		vp(3'b010);
		rc("adj_min", `HRPWM_A_ADJ_BUF, 32'h0f0);
		close_out();
	end
endmodule

/* hw/hrpwm_stage.sv */
`timescale 1ns/10ps
`include "hrpwm_params.svh"

// What this block does
// - sixteen phase taps per oscillator period
// - fine duty field selects the phase tap
// - phase time 1.5x nominal is lock loss
// - protection on: recover within 30us, set flag
// - protection off: no recovery, flag stays zero
// - wait programmed delay after each adjust trigger
// - separate 0..15 step counts per voltage condition
// - direction bit picks over-voltage raise or lower
// - voltage levels trigger adjust while enabled
// - complementary pair with dead-time enable bit
// - dead time delays out_high at each pwm rising edge, none on out_low
// - per-output inversion bits
// - faults force outputs, recover when cleared
// - event pulse per over-current or voltage fault
// - fine write buffered, coarse write loads it
// - coarse read latches fine into buffer
// - debounced over-current flag
// - per-output over-current forcing enables
// - over-current event gated by its enable
// - new duty, dead time, period at zero
// - delay is (field+1) times two periods
// - hardware control bit set by levels, guarded clear
module hrpwm_stage (
	input  wire logic                  sys_clk,
	input  wire logic                  reset_n,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic [31:0]                hrdata,
	output logic                       hresp,
	input  wire hrpwm_pkg::hrpwm_sense_s sense,
	output hrpwm_pkg::hrpwm_drive_s    drive
);

	hrpwm_pkg::hrpwm_state_s s;
	hrpwm_pkg::hrpwm_state_s n;
	logic                    hresp_reg;

	always_comb begin
		logic        ov;
		logic        uv;
		logic        acc;
		logic        wrap;
		logic        pwm_n;
		logic        rise;
		logic        perr;
		logic        inc;
		logic        force_h;
		logic        force_l;
		logic        high_raw;
		logic [9:0]  ph2;
		logic [9:0]  nom3;
		logic [6:0]  thr;
		logic [3:0]  stp;
		logic [11:0] base;
		logic [12:0] sum;
		logic [11:0] nv;
		n = s;
		// locals start defined so no path leaves one floating
		wrap     = 1'b0;
		pwm_n    = 1'b0;
		rise     = 1'b0;
		perr     = 1'b0;
		inc      = 1'b0;
		force_h  = 1'b0;
		force_l  = 1'b0;
		high_raw = 1'b0;
		ph2      = 10'h000;
		nom3     = 10'h000;
		thr      = 7'h00;
		stp      = 4'h0;
		base     = 12'h000;
		sum      = 13'h0000;
		nv       = 12'h000;
		ov = s.sn2.ov_level;
		uv = s.sn2.uv_level;
		acc = hsel & hready & htrans[1];
		n.sn1 = sense;
		n.sn2 = s.sn1;
		n.hready = 1'b1;

		// register writes land in the data phase
		if (s.wr_pend) begin
			unique case (s.wr_addr)
				`HRPWM_A_CTRL: begin
					n.run     = hwdata[`HRPWM_C_RUN];
					n.dt_en   = hwdata[`HRPWM_C_DT_EN];
					n.lk_en   = hwdata[`HRPWM_C_LOCK_EN];
					n.adj_en  = hwdata[`HRPWM_C_ADJ_EN];
					n.adj_dir = hwdata[`HRPWM_C_ADJ_DIR];
					n.deb_sel = hwdata[`HRPWM_C_DEB_LSB +: 3];
					n.ocp_ie  = hwdata[`HRPWM_C_OCP_IE];
					if (!hwdata[`HRPWM_C_HW_CTL] && !ov && !uv) begin
						n.hw_ctl = 1'b0;
					end
				end
				`HRPWM_A_PERIOD:    n.period = hwdata[7:0];
				`HRPWM_A_COARSE: begin
					n.coarse = hwdata[7:0];
					n.fine   = s.fine_hold;
				end
				`HRPWM_A_FINE:      n.fine_hold = hwdata[3:0];
				`HRPWM_A_DEADTIME:  n.dt_len = hwdata[4:0];
				`HRPWM_A_ADJ_DELAY: n.adj_dly = hwdata[5:0];
				`HRPWM_A_ADJ_STEPS: n.adj_steps = hwdata[7:0];
				`HRPWM_A_DUTY_MAX:  n.dmax = hwdata[11:0];
				`HRPWM_A_DUTY_MIN:  n.dmin = hwdata[11:0];
				`HRPWM_A_OUT_CTRL: begin
					n.inv_l   = hwdata[`HRPWM_O_INV_L];
					n.inv_h   = hwdata[`HRPWM_O_INV_H];
					n.flev_l  = hwdata[`HRPWM_O_FLEV_L];
					n.flev_h  = hwdata[`HRPWM_O_FLEV_H];
					n.ocpen_l = hwdata[`HRPWM_O_OCPEN_L];
					n.ocpen_h = hwdata[`HRPWM_O_OCPEN_H];
				end
				`HRPWM_A_STATUS: begin
					if (hwdata[`HRPWM_S_LOCK_FLAG]) begin
						n.lk_flag = 1'b0;
					end
				end
				`HRPWM_A_PHASE_NOM: n.phase_nom = hwdata[7:0];
				default: ;
			endcase
		end
		n.wr_pend = acc & hwrite;
		n.wr_addr = haddr[7:0];

		// read data is captured in the address phase, so reads cost no wait state
		n.hrdata = 32'h0000_0000;
		if (acc && !hwrite) begin
			unique case (haddr[7:0])
				`HRPWM_A_CTRL: n.hrdata = {15'h0000, s.ocp_ie, 5'h00, s.deb_sel, 2'h0, s.hw_ctl,
					s.adj_dir, s.adj_en, s.lk_en, s.dt_en, s.run};
				`HRPWM_A_PERIOD:    n.hrdata = {24'h000000, s.period};
				`HRPWM_A_COARSE: begin
					n.hrdata    = {24'h000000, s.coarse};
					n.fine_hold = s.fine;
				end
				`HRPWM_A_FINE:      n.hrdata = {28'h0000000, s.fine_hold};
				`HRPWM_A_DEADTIME:  n.hrdata = {27'h0000000, s.dt_len};
				`HRPWM_A_ADJ_DELAY: n.hrdata = {26'h0000000, s.adj_dly};
				`HRPWM_A_ADJ_STEPS: n.hrdata = {24'h000000, s.adj_steps};
				`HRPWM_A_DUTY_MAX:  n.hrdata = {20'h00000, s.dmax};
				`HRPWM_A_DUTY_MIN:  n.hrdata = {20'h00000, s.dmin};
				`HRPWM_A_ADJ_BUF:   n.hrdata = {20'h00000, s.abuf};
				`HRPWM_A_OUT_CTRL: n.hrdata = {22'h000000, s.ocpen_h, s.ocpen_l, 2'h0,
					s.flev_h, s.flev_l, 2'h0, s.inv_h, s.inv_l};
				`HRPWM_A_STATUS: n.hrdata = {26'h0000000, s.adj_st == hrpwm_pkg::adj_wait,
					s.hw_ctl, uv, ov, s.ocf, s.lk_flag};
				`HRPWM_A_PHASE_NOM: n.hrdata = {24'h000000, s.phase_nom};
				default:            n.hrdata = 32'h0000_0000;
			endcase
		end

		// period counter; shadows reload only as the count returns to zero
		wrap = s.cnt >= s.a_period;
		n.cnt = (wrap || !s.run) ? 8'h00 : s.cnt + 8'h01;
		if (wrap || !s.run) begin
			n.a_period = s.period;
			n.a_duty   = s.hw_ctl ? s.abuf : {s.coarse, s.fine};
			n.a_dt     = s.dt_len;
		end

		// coarse edge here; the tap select trims it inside the last cycle
		pwm_n = s.run & ((s.cnt < s.a_duty[11:4]) |
			((s.cnt == s.a_duty[11:4]) & (s.a_duty[3:0] != 4'h0)));
		n.pwm = pwm_n;
		rise = pwm_n & ~s.pwm;
		if (rise && s.dt_en) begin
			n.dt_cnt = s.a_dt;
		end else if (s.dt_cnt != 5'h00) begin
			n.dt_cnt = s.dt_cnt - 5'h01;
		end else begin
			n.dt_cnt = 5'h00;
		end
		high_raw = s.pwm & (s.dt_cnt == 5'h00);
		n.drv.hires = s.pwm;
		n.drv.tap   = s.a_duty[3:0];

		// lock monitor: 2*t >= 3*nominal means t reached 1.5x
		ph2  = {1'b0, s.sn2.phase_time, 1'b0};
		nom3 = {2'b00, s.phase_nom} + {1'b0, s.phase_nom, 1'b0};
		perr = (s.phase_nom != 8'h00) && (ph2 >= nom3);
		if (!s.lk_en) begin
			n.lk_flag = 1'b0;
			n.rec_cnt = 9'h000;
		end else if (perr && s.rec_cnt == 9'h000) begin
			n.rec_cnt = 9'(`HRPWM_LOCK_CYC);
			n.lk_flag = 1'b1;
		end else if (s.rec_cnt != 9'h000) begin
			n.rec_cnt = s.rec_cnt - 9'h001;
		end
		n.drv.relock = n.rec_cnt != 9'h000;

		// over-current debounce; hold time roughly 2^sel cycles
		thr = (7'h01 << s.deb_sel) - 7'h01;
		if (s.deb_sel == 3'h0) begin
			n.ocf = s.sn2.ocp_raw;
			n.deb_cnt = 7'h00;
		end else if (s.sn2.ocp_raw == s.ocf) begin
			n.deb_cnt = 7'h00;
		end else if (s.deb_cnt + 7'h01 >= thr) begin
			n.ocf = s.sn2.ocp_raw;
			n.deb_cnt = 7'h00;
		end else begin
			n.deb_cnt = s.deb_cnt + 7'h01;
		end

		// auto-adjust; over-voltage wins when both levels stand
		inc  = ov ? ~s.adj_dir : s.adj_dir;
		stp  = ov ? s.adj_steps[7:4] : s.adj_steps[3:0];
		base = s.hw_ctl ? s.abuf : {s.coarse, s.fine};
		sum  = {1'b0, base} + {9'h000, stp};
		if (inc) begin
			nv = sum[12] ? 12'hfff : sum[11:0];
		end else begin
			nv = (base < {8'h00, stp}) ? 12'h000 : base - {8'h00, stp};
		end
		if (nv > s.dmax) begin
			nv = s.dmax;
		end
		if (nv < s.dmin) begin
			nv = s.dmin;
		end
		if (!s.adj_en) begin
			n.adj_st = hrpwm_pkg::adj_idle;
			n.hw_ctl = 1'b0;
		end else begin
			if (ov || uv) begin
				n.hw_ctl = 1'b1;
			end
			unique case (s.adj_st)
				hrpwm_pkg::adj_idle: begin
					if (ov || uv) begin
						n.abuf    = nv;
						n.dly_cnt = {({1'b0, s.adj_dly} + 7'h01), 1'b0};
						n.adj_st  = hrpwm_pkg::adj_wait;
					end
				end
				hrpwm_pkg::adj_wait: begin
					if (s.dly_cnt == 8'h00) begin
						n.adj_st = hrpwm_pkg::adj_idle;
					end else if (wrap) begin
						n.dly_cnt = s.dly_cnt - 8'h01;
					end
				end
			endcase
		end

		// output stage: fault or stopped forces, otherwise inverted as asked
		force_h = ~s.run | ov | uv | (s.ocf & s.ocpen_h);
		force_l = ~s.run | ov | uv | (s.ocf & s.ocpen_l);
		n.drv.out_high = force_h ? s.flev_h : (high_raw ^ s.inv_h);
		n.drv.out_low  = force_l ? s.flev_l : (~s.pwm ^ s.inv_l);
		n.ov_d = ov;
		n.uv_d = uv;
		n.drv.irq_ocp = s.ocp_ie & n.ocf & ~s.ocf;
		n.drv.irq_ovp = ov & ~s.ov_d;
		n.drv.irq_uvp = uv & ~s.uv_d;
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			s <= '0;
			s.hready <= 1'b1;
			hresp_reg <= 1'b0;
		end else begin
			s <= n;
			hresp_reg <= 1'b0;
		end
	end

	assign hreadyout = s.hready;
	assign hrdata    = s.hrdata;
	assign hresp     = hresp_reg;
	assign drive     = s.drv;

	sequence s_coarse_wr;
		s.wr_pend && s.wr_addr == `HRPWM_A_COARSE;
	endsequence

	sequence s_coarse_rd;
		hsel && hready && htrans[1] && !hwrite && haddr[7:0] == `HRPWM_A_COARSE;
	endsequence

	property p_lock_off;
		@(posedge sys_clk) disable iff (!reset_n) !s.lk_en |=> !s.lk_flag && !s.drv.relock;
	endproperty
	a_lock_off: assert property (p_lock_off) else $error("lock flag set while protection off");

	property p_lock_recover;
		@(posedge sys_clk) disable iff (!reset_n) $rose(s.drv.relock) |-> s.lk_flag ##[1:301] !s.drv.relock;
	endproperty
	a_lock_recover: assert property (p_lock_recover) else $error("lock recovery too long");

	property p_fine_load;
		@(posedge sys_clk) disable iff (!reset_n) s_coarse_wr |=> s.fine == $past(s.fine_hold);
	endproperty
	a_fine_load: assert property (p_fine_load) else $error("coarse write did not load fine");

	property p_fine_latch;
		@(posedge sys_clk) disable iff (!reset_n) s_coarse_rd |=> s.fine_hold == $past(s.fine);
	endproperty
	a_fine_latch: assert property (p_fine_latch) else $error("coarse read did not latch fine");

	property p_shadow;
		@(posedge sys_clk) disable iff (!reset_n) !$stable(s.a_duty) |-> s.cnt == 8'h00;
	endproperty
	a_shadow: assert property (p_shadow) else $error("duty changed mid period");

	property p_clamp;
		@(posedge sys_clk) disable iff (!reset_n)
			(s.dmin <= s.dmax) && $changed(s.abuf) |-> s.abuf <= s.dmax && s.abuf >= s.dmin;
	endproperty
	a_clamp: assert property (p_clamp) else $error("adjusted duty outside limits");

	property p_hw_off;
		@(posedge sys_clk) disable iff (!reset_n) !s.adj_en |=> !s.hw_ctl;
	endproperty
	a_hw_off: assert property (p_hw_off) else $error("hardware control set while adjust off");

	property p_force;
		@(posedge sys_clk) disable iff (!reset_n)
			(s.sn2.ov_level || s.sn2.uv_level) |=> s.drv.out_high == $past(s.flev_h) && s.drv.out_low == $past(s.flev_l);
	endproperty
	a_force: assert property (p_force) else $error("outputs not forced on voltage fault");

	property p_ocp_irq;
		@(posedge sys_clk) disable iff (!reset_n) s.drv.irq_ocp |-> $past(s.ocp_ie) && s.ocf;
	endproperty
	a_ocp_irq: assert property (p_ocp_irq) else $error("over-current event without enable");

	property p_dt_load;
		@(posedge sys_clk) disable iff (!reset_n) $rose(s.pwm) && $past(s.dt_en) |-> s.dt_cnt == $past(s.a_dt);
	endproperty
	a_dt_load: assert property (p_dt_load) else $error("dead time not loaded at rising edge");

	property p_ov_event;
		@(posedge sys_clk) disable iff (!reset_n) $rose(s.sn2.ov_level) |=> s.drv.irq_ovp ##1 !s.drv.irq_ovp;
	endproperty
	a_ov_event: assert property (p_ov_event) else $error("over-voltage event not one pulse");

	property p_uv_event;
		@(posedge sys_clk) disable iff (!reset_n) $rose(s.sn2.uv_level) |=> s.drv.irq_uvp ##1 !s.drv.irq_uvp;
	endproperty
	a_uv_event: assert property (p_uv_event) else $error("under-voltage event not one pulse");

	sequence s_adj_trig;
		s.adj_en && s.adj_st == hrpwm_pkg::adj_idle && (s.sn2.ov_level || s.sn2.uv_level);
	endsequence

	property p_adj_start;
		@(posedge sys_clk) disable iff (!reset_n)
			s_adj_trig |=> s.adj_st == hrpwm_pkg::adj_wait && s.hw_ctl &&
				s.dly_cnt == {1'b0, $past(s.adj_dly), 1'b0} + 8'h02;
	endproperty
	a_adj_start: assert property (p_adj_start) else $error("adjust trigger did not start delay");

	property p_adj_hold;
		@(posedge sys_clk) disable iff (!reset_n)
			s.adj_en && s.adj_st == hrpwm_pkg::adj_wait && s.dly_cnt != 8'h00 |=>
				s.adj_st == hrpwm_pkg::adj_wait && $stable(s.abuf);
	endproperty
	a_adj_hold: assert property (p_adj_hold) else $error("adjust acted during delay");

	property p_deb_bypass;
		@(posedge sys_clk) disable iff (!reset_n) s.deb_sel == 3'h0 |=> s.ocf == $past(s.sn2.ocp_raw);
	endproperty
	a_deb_bypass: assert property (p_deb_bypass) else $error("bypassed over-current flag lags");

endmodule

/* inc/hrpwm_params.svh */
`ifndef HRPWM_PARAMS_SVH
`define HRPWM_PARAMS_SVH

`define HRPWM_A_CTRL      8'h00
`define HRPWM_A_PERIOD    8'h04
`define HRPWM_A_COARSE    8'h08
`define HRPWM_A_FINE      8'h0c
`define HRPWM_A_DEADTIME  8'h10
`define HRPWM_A_ADJ_DELAY 8'h14
`define HRPWM_A_ADJ_STEPS 8'h18
`define HRPWM_A_DUTY_MAX  8'h1c
`define HRPWM_A_DUTY_MIN  8'h20
`define HRPWM_A_ADJ_BUF   8'h24
`define HRPWM_A_OUT_CTRL  8'h28
`define HRPWM_A_STATUS    8'h2c
`define HRPWM_A_PHASE_NOM 8'h30

`define HRPWM_C_RUN       0
`define HRPWM_C_DT_EN     1
`define HRPWM_C_LOCK_EN   2
`define HRPWM_C_ADJ_EN    3
`define HRPWM_C_ADJ_DIR   4
`define HRPWM_C_HW_CTL    5
`define HRPWM_C_DEB_LSB   8
`define HRPWM_C_OCP_IE    16

`define HRPWM_O_INV_L     0
`define HRPWM_O_INV_H     1
`define HRPWM_O_FLEV_L    4
`define HRPWM_O_FLEV_H    5
`define HRPWM_O_OCPEN_L   8
`define HRPWM_O_OCPEN_H   9

`define HRPWM_S_LOCK_FLAG 0

`define HRPWM_CLK_PERIOD_NS 100
`define HRPWM_LOCK_RECOVER_NS 30000
`define HRPWM_LOCK_CYC (`HRPWM_LOCK_RECOVER_NS / `HRPWM_CLK_PERIOD_NS)

`endif

/* inc/hrpwm_pkg.sv */
package hrpwm_pkg;

	typedef enum logic {adj_idle, adj_wait} hrpwm_adj_e;

	typedef struct packed {
		logic       ocp_raw;
		logic       ov_level;
		logic       uv_level;
		logic [7:0] phase_time;
	} hrpwm_sense_s;

	typedef struct packed {
		logic       out_high;
		logic       out_low;
		logic       hires;
		logic [3:0] tap;
		logic       relock;
		logic       irq_ocp;
		logic       irq_ovp;
		logic       irq_uvp;
	} hrpwm_drive_s;

	typedef struct packed {
		hrpwm_sense_s sn1, sn2;
		logic         run, dt_en, lk_en, adj_en, adj_dir, hw_ctl, ocp_ie;
		logic [2:0]   deb_sel;
		logic [7:0]   period, coarse, adj_steps, phase_nom;
		logic [3:0]   fine, fine_hold;
		logic [4:0]   dt_len, a_dt, dt_cnt;
		logic [5:0]   adj_dly;
		logic [11:0]  dmax, dmin, abuf, a_duty;
		logic         inv_l, inv_h, flev_l, flev_h, ocpen_l, ocpen_h;
		logic [7:0]   a_period, cnt, dly_cnt;
		logic         pwm, lk_flag, ocf, ov_d, uv_d;
		logic [8:0]   rec_cnt;
		logic [6:0]   deb_cnt;
		hrpwm_adj_e   adj_st;
		logic         wr_pend;
		logic [7:0]   wr_addr;
		logic [31:0]  hrdata;
		logic         hready;
		hrpwm_drive_s drv;
	} hrpwm_state_s;

endpackage
